// ===== pbma_dev.sv
/*
 buffer manager side: data window, offset pointer, staging, queue counters,
 command register. assumes the host issues one access at a time over pbma_if.
*/
`timescale 1ns/1ps
module pbma_dev
   import pbma_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic ce,
   pbma_if.dev bus,
   input wire logic [4:0] rx_top_packet,
   output logic alloc_req,
   output logic [3:0] alloc_pages,
   output logic [4:0] enq_packet,
   output logic [3:0] cur_endpoint
);
   logic [7:0] ram [0:RAM_WORDS-1];
   logic [7:0] low_stage_ff;
   logic [10:0] ptr_ff;
   logic [10:0] last_used_ff;
   logic src_ff;
   logic auto_ff;
   logic dir_rd_ff;
   logic [3:0] ep_ff;
   logic [4:0] pkt_ff;
   logic [7:0] rd_stage_ff;
   logic [7:0] rdata_ff;
   logic ack_ff;
   logic alloc_ff;
   logic [3:0] pages_ff;
   logic [15:0] qpush;
   logic [15:0] qpop;
   logic [15:0] qclr;
   logic [2:0] qcnt [0:15];
   logic [4:0] cur_pkt;
   logic [11:0] ram_addr;
   logic acc;
   logic win_acc;
   logic [10:0] nxt_ptr;

   assign acc = bus.req && ce && !ack_ff;
   assign win_acc = acc && bus.addr == WINDOW_ADDR;
   assign cur_pkt = src_ff ? rx_top_packet : pkt_ff;
   assign ram_addr = {cur_pkt[0], ptr_ff};
   assign nxt_ptr = (auto_ff && ptr_ff != MAX_OFFSET) ? ptr_ff + 11'd1 : ptr_ff;

   // one-cycle answer keeps every window access inside the bound
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ack_ff <= 1'b0;
      end else if (ce) begin
         ack_ff <= acc;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         low_stage_ff <= 8'h00;
         ptr_ff <= 11'h000;
         last_used_ff <= 11'h000;
         src_ff <= 1'b0;
         auto_ff <= 1'b0;
         dir_rd_ff <= 1'b0;
      end else if (acc && bus.wr && bus.addr == OFS_LOW_ADDR) begin
         low_stage_ff <= bus.wdata;
      end else if (acc && bus.wr && bus.addr == OFS_HIGH_ADDR) begin
         ptr_ff <= {bus.wdata[2:0], low_stage_ff};
         src_ff <= bus.wdata[SRC_BIT];
         auto_ff <= bus.wdata[AUTO_BIT];
         dir_rd_ff <= bus.wdata[DIR_BIT];
      end else if (win_acc) begin
         last_used_ff <= ptr_ff;
         ptr_ff <= nxt_ptr;
      end
   end

   // read staging refilled every enabled cycle from the current pointer while the direction bit selects read
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_stage_ff <= 8'h00;
      end else if (ce && dir_rd_ff) begin
         rd_stage_ff <= ram[ram_addr];
      end
   end

   // write lands in the same cycle it is taken
   always_ff @(posedge sys_clk) begin
      if (win_acc && bus.wr && !dir_rd_ff) begin
         ram[ram_addr] <= bus.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ep_ff <= 4'h0;
         pkt_ff <= 5'h00;
      end else if (acc && bus.wr && bus.addr == TXSEL_ADDR) begin
         ep_ff <= bus.wdata[3:0];
      end else if (acc && bus.wr && bus.addr == PKTSEL_ADDR) begin
         pkt_ff <= bus.wdata[4:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         alloc_ff <= 1'b0;
         pages_ff <= 4'h0;
      end else if (ce) begin
         alloc_ff <= 1'b0;
         if (acc && bus.wr && bus.addr == CMD_ADDR && bus.wdata[7:5] == CMD_ALLOC
               && bus.wdata[3:0] < 4'(MAX_PAGES)) begin
            alloc_ff <= 1'b1;
            pages_ff <= bus.wdata[3:0];
         end
      end
   end

   always_comb begin
      qpush = 16'h0000;
      qclr = 16'h0000;
      qpop = 16'h0000;
      if (acc && bus.wr && bus.addr == CMD_ADDR) begin
         if (bus.wdata[7:5] == CMD_ENQUEUE) begin
            qpush[ep_ff] = 1'b1;
         end else if (bus.wdata[7:5] == CMD_EP_RESET) begin
            qclr[ep_ff] = 1'b1;
         end
      end
      if (bus.tx_pop) begin
         qpop[bus.tx_pop_ep] = 1'b1;
      end
   end

   for (genvar i = 0; i < 16; i++) begin : g_q
      pbma_qcnt u_q (
         .sys_clk(sys_clk),
         .srst(srst),
         .ce(ce),
         .push(qpush[i]),
         .pop(qpop[i]),
         .clr(qclr[i]),
         .count(qcnt[i])
      );
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_ff <= 8'h00;
      end else if (acc && !bus.wr) begin
         if (bus.addr == WINDOW_ADDR) begin
            rdata_ff <= rd_stage_ff;
         end else if (bus.addr >= QCNT_BASE && bus.addr <= QCNT_LAST) begin
            rdata_ff <= {5'h00, qcnt[bus.addr[3:0]]};
         end else if (bus.addr == OFS_LOW_ADDR) begin
            rdata_ff <= last_used_ff[7:0];
         end else if (bus.addr == OFS_HIGH_ADDR) begin
            rdata_ff <= {src_ff, auto_ff, dir_rd_ff, 2'b00, ptr_ff[10:8]};
         end else if (bus.addr == TXSEL_ADDR) begin
            rdata_ff <= {4'h0, ep_ff};
         end else if (bus.addr == PKTSEL_ADDR) begin
            rdata_ff <= {3'h0, pkt_ff};
         end else begin
            rdata_ff <= 8'h00;
         end
      end
   end

   assign bus.rdata = rdata_ff;
   assign bus.ack = ack_ff;
   assign alloc_req = alloc_ff;
   assign alloc_pages = pages_ff;
   assign enq_packet = pkt_ff;
   assign cur_endpoint = ep_ff;
endmodule : pbma_dev

// ===== pbma_host.sv
/*
 microcontroller end: AXI4-Lite slave with own registers, issues one access
 at a time on pbma_if, inserting mandated waits.
*/
`timescale 1ns/1ps
module pbma_host
   import pbma_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic ce,
   pbma_if.host bus,
   input wire logic [3:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [3:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   logic [15:0] addr_ff;
   logic [7:0] wdat_ff;
   logic [7:0] rdat_ff;
   logic busy_ff;
   logic go_wr_ff;
   logic req_ff;
   logic [9:0] wait_ff;
   logic last_win_wr_ff;
   logic aw_ok_ff;
   logic w_ok_ff;
   logic [3:0] awa_ff;
   logic [31:0] wd_ff;
   logic bvalid_ff;
   logic rvalid_ff;
   logic [31:0] rd_ff;
   logic start;
   logic pop_ff;
   logic [3:0] pop_ep_ff;

   assign s_awready = !aw_ok_ff && !bvalid_ff;
   assign s_wready = !w_ok_ff && !bvalid_ff;
   assign s_arready = !rvalid_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
         awa_ff <= 4'h0;
         wd_ff <= 32'h0;
         bvalid_ff <= 1'b0;
      end else if (ce) begin
         if (s_awvalid && s_awready) begin
            aw_ok_ff <= 1'b1;
            awa_ff <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_ok_ff <= 1'b1;
            wd_ff <= s_wdata;
         end
         if (aw_ok_ff && w_ok_ff) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            bvalid_ff <= 1'b1;
         end else if (bvalid_ff && s_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // writing ctrl bit0 starts an access; bit1 selects write; bit2 pops a queue
   assign start = aw_ok_ff && w_ok_ff && awa_ff == AXI_CTRL && wd_ff[0] && !busy_ff;

   // one-cycle transmit pop for the endpoint held in the address register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pop_ff <= 1'b0;
         pop_ep_ff <= 4'h0;
      end else if (ce) begin
         pop_ff <= aw_ok_ff && w_ok_ff && awa_ff == AXI_CTRL && wd_ff[2];
         pop_ep_ff <= addr_ff[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         addr_ff <= 16'h0000;
         wdat_ff <= 8'h00;
      end else if (ce && aw_ok_ff && w_ok_ff) begin
         if (awa_ff == AXI_ADDR) begin
            addr_ff <= wd_ff[15:0];
         end else if (awa_ff == AXI_WDATA) begin
            wdat_ff <= wd_ff[7:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         busy_ff <= 1'b0;
         go_wr_ff <= 1'b0;
         req_ff <= 1'b0;
         wait_ff <= 10'h000;
         rdat_ff <= 8'h00;
         last_win_wr_ff <= 1'b0;
      end else if (ce) begin
         if (start) begin
            busy_ff <= 1'b1;
            go_wr_ff <= wd_ff[1];
            // hold off reads after a pointer change or recent window write
            // window-write flag stays set until one long wait has been served
            if (!wd_ff[1] && last_win_wr_ff) begin
               wait_ff <= 10'(HOST_WR_WAIT_CYC);
               last_win_wr_ff <= 1'b0;
            end else if (!wd_ff[1] && addr_ff == WINDOW_ADDR) begin
               wait_ff <= 10'(HOST_RD_WAIT_CYC);
            end else if ((addr_ff == OFS_HIGH_ADDR || addr_ff == PKTSEL_ADDR)
                  && last_win_wr_ff) begin
               wait_ff <= 10'(HOST_WR_WAIT_CYC);
               last_win_wr_ff <= 1'b0;
            end else begin
               wait_ff <= 10'h000;
            end
         end else if (busy_ff && !req_ff && wait_ff != 10'h000) begin
            wait_ff <= wait_ff - 10'h001;
         end else if (busy_ff && !req_ff) begin
            req_ff <= 1'b1;
         end else if (req_ff && bus.ack) begin
            req_ff <= 1'b0;
            busy_ff <= 1'b0;
            rdat_ff <= bus.rdata;
            if (go_wr_ff && addr_ff == WINDOW_ADDR) begin
               last_win_wr_ff <= 1'b1;
            end
         end
      end
   end

   assign bus.req = req_ff;
   assign bus.wr = go_wr_ff;
   assign bus.addr = addr_ff;
   assign bus.wdata = wdat_ff;
   assign bus.tx_pop = pop_ff;
   assign bus.tx_pop_ep = pop_ep_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rvalid_ff <= 1'b0;
         rd_ff <= 32'h0;
      end else if (ce) begin
         if (s_arvalid && s_arready) begin
            rvalid_ff <= 1'b1;
            if (s_araddr == AXI_CTRL) begin
               rd_ff <= {31'h0, busy_ff};
            end else if (s_araddr == AXI_ADDR) begin
               rd_ff <= {16'h0, addr_ff};
            end else if (s_araddr == AXI_WDATA) begin
               rd_ff <= {24'h0, wdat_ff};
            end else if (s_araddr == AXI_RDATA) begin
               rd_ff <= {24'h0, rdat_ff};
            end else begin
               rd_ff <= 32'h0;
            end
         end else if (rvalid_ff && s_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign s_rdata = rd_ff;
   assign s_rvalid = rvalid_ff;
   assign s_rresp = 2'b00;
   assign s_bvalid = bvalid_ff;
   assign s_bresp = 2'b00;
endmodule : pbma_host

// ===== pbma_if.sv
/*
 register-bus link between the microcontroller side and the buffer manager.
 one clock, both ends sample on its rising edge.
*/
`timescale 1ns/1ps
interface pbma_if;
   logic req;
   logic wr;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack;
   logic tx_pop;
   logic [3:0] tx_pop_ep;
   modport dev (input req, input wr, input addr, input wdata, input tx_pop,
      input tx_pop_ep, output rdata, output ack);
   modport host (output req, output wr, output addr, output wdata, output tx_pop,
      output tx_pop_ep, input rdata, input ack);
endinterface : pbma_if

// ===== pbma_pkg.sv
/*
 package for packet-buffer access logic: register offsets, field positions,
 command codes, timing constants.
 assumes nothing beyond a SystemVerilog compiler.
*/
package pbma_pkg;
   localparam int CLK_MHZ = 250;
   localparam logic [15:0] WINDOW_ADDR = 16'h6000;
   localparam logic [15:0] QCNT_BASE = 16'h7f40;
   localparam logic [15:0] QCNT_LAST = 16'h7f4f;
   localparam logic [15:0] OFS_LOW_ADDR = 16'h7f50;
   localparam logic [15:0] OFS_HIGH_ADDR = 16'h7f51;
   localparam logic [15:0] TXSEL_ADDR = 16'h7f52;
   localparam logic [15:0] CMD_ADDR = 16'h7f53;
   localparam logic [15:0] PKTSEL_ADDR = 16'h7f55;
   localparam int SRC_BIT = 7;
   localparam int AUTO_BIT = 6;
   localparam int DIR_BIT = 5;
   localparam logic [2:0] CMD_NOOP = 3'h0;
   localparam logic [2:0] CMD_ALLOC = 3'h1;
   localparam logic [2:0] CMD_ENQUEUE = 3'h6;
   localparam logic [2:0] CMD_EP_RESET = 3'h7;
   localparam int PAGE_BYTES = 128;
   localparam int MAX_PAGES = 10;
   localparam logic [10:0] MAX_OFFSET = 11'd1277;
   localparam int RD_FILL_NS = 1218;
   localparam int WR_DRAIN_NS = 2520;
   localparam int SEQ_ACCESS_NS = 588;
   localparam int RD_FILL_CYC = RD_FILL_NS * CLK_MHZ / 1000;
   localparam int WR_DRAIN_CYC = WR_DRAIN_NS * CLK_MHZ / 1000;
   localparam int SEQ_ACCESS_CYC = SEQ_ACCESS_NS * CLK_MHZ / 1000;
   localparam int HOST_RD_WAIT_NS = 167;
   localparam int HOST_WR_WAIT_NS = 2500;
   localparam int HOST_RD_WAIT_CYC = (HOST_RD_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int HOST_WR_WAIT_CYC = (HOST_WR_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int RAM_WORDS = 4096;
   localparam logic [2:0] QMAX = 3'h5;
   localparam logic [3:0] AXI_CTRL = 4'h0;
   localparam logic [3:0] AXI_ADDR = 4'h4;
   localparam logic [3:0] AXI_WDATA = 4'h8;
   localparam logic [3:0] AXI_RDATA = 4'hc;
   typedef enum logic [1:0] {PB_IDLE, PB_DEV, PB_DONE} pbma_state_type;
endpackage : pbma_pkg

// ===== pbma_properties.sv
/*
 checker for the register link between the host end and the buffer manager.
 assumes instantiation beside pbma_if with its signals connected by name.
*/
`timescale 1ns/1ps
module pbma_properties
   import pbma_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic req,
   input wire logic wr,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic ack,
   input wire logic tx_pop,
   input wire logic [3:0] tx_pop_ep
);
   // gaps in clocks before the taking edge, one less than elapsed cycles
   localparam logic [15:0] RD_GAP = 16'd41;
   localparam logic [15:0] WR_GAP = 16'd62;
   localparam logic [15:0] DIR_GAP = 16'd59;
   logic [15:0] since_high_ff;
   logic [15:0] since_wwr_ff;
   logic rd_win;
   assign rd_win = req && !ack && !wr && addr == WINDOW_ADDR;
   always_ff @(posedge sys_clk) begin
      if (srst) since_high_ff <= 16'hffff;
      else if (ack && wr && addr == OFS_HIGH_ADDR) since_high_ff <= 16'h0;
      else if (since_high_ff != 16'hffff) since_high_ff <= since_high_ff + 16'h1;
   end
   always_ff @(posedge sys_clk) begin
      if (srst) since_wwr_ff <= 16'hffff;
      else if (ack && wr && addr == WINDOW_ADDR) since_wwr_ff <= 16'h0;
      else if (since_wwr_ff != 16'hffff) since_wwr_ff <= since_wwr_ff + 16'h1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   property p_ack_next; req && !ack |=> ack; endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not answered on the next cycle");
   property p_ack_single; ack |=> !ack && !req; endproperty
   a_ack_single: assert property (p_ack_single)
      else $error("answer or request outlived one access");
   property p_req_steady; req && !ack |=> $stable(addr) && $stable(wr) && $stable(wdata);
   endproperty
   a_req_steady: assert property (p_req_steady)
      else $error("request changed while waiting");
   property p_rd_after_high; rd_win |-> since_high_ff >= RD_GAP; endproperty
   a_rd_after_high: assert property (p_rd_after_high)
      else $error("window read too soon after pointer change");
   property p_rd_after_wr; rd_win |-> since_wwr_ff >= WR_GAP; endproperty
   a_rd_after_wr: assert property (p_rd_after_wr)
      else $error("window read too soon after window write");
   property p_dir_flip;
      req && !ack && wr && addr == OFS_HIGH_ADDR && wdata[DIR_BIT] |-> since_wwr_ff >= DIR_GAP;
   endproperty
   a_dir_flip: assert property (p_dir_flip)
      else $error("direction set to read too soon after window write");
   property p_qcnt_upper;
      ack && !wr && addr >= QCNT_BASE && addr <= QCNT_LAST |-> rdata[7:3] == 5'h0;
   endproperty
   a_qcnt_upper: assert property (p_qcnt_upper)
      else $error("queue counter upper bits not zero");
   property p_high_rsvd; ack && !wr && addr == OFS_HIGH_ADDR |-> rdata[4:3] == 2'h0; endproperty
   a_high_rsvd: assert property (p_high_rsvd)
      else $error("high pointer reserved bits not zero");
   property p_cmd_zero; ack && !wr && addr == CMD_ADDR |-> rdata == 8'h0; endproperty
   a_cmd_zero: assert property (p_cmd_zero)
      else $error("command register read not zero");
   c_win_read: cover property (ack && !wr && addr == WINDOW_ADDR);
   c_win_write: cover property (ack && wr && addr == WINDOW_ADDR);
   c_cmd_write: cover property (ack && wr && addr == CMD_ADDR);
   c_tx_pop: cover property (tx_pop && tx_pop_ep == 4'h3);
endmodule : pbma_properties

// ===== pbma_qcnt.sv
/*
 one endpoint transmit queue counter, saturating at both ends.
 assumes push, pop and clear on sys_clk.
*/
`timescale 1ns/1ps
module pbma_qcnt
   import pbma_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic push,
   input wire logic pop,
   input wire logic clr,
   output logic [2:0] count
);
   logic [2:0] cnt_ff;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_ff <= 3'h0;
      end else if (ce) begin
         if (clr) begin
            cnt_ff <= 3'h0;
         end else if (push && !pop && cnt_ff != QMAX) begin
            cnt_ff <= cnt_ff + 3'h1;
         end else if (pop && !push && cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
         end
      end
   end
   assign count = cnt_ff;
endmodule : pbma_qcnt

// ===== tb_packet_buffer_mcu_access.sv
/*
 testbench: host end and buffer manager joined by pbma_if, driven over AXI4-Lite.
 assumes the host sequences window accesses and their waits itself.
*/
`timescale 1ns/1ps
module tb_packet_buffer_mcu_access
   import pbma_pkg::*;
;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [4:0] rx_top_packet = 5'h0;
   logic [3:0] s_awaddr = 4'h0;
   logic s_awvalid = 1'b0;
   logic s_awready;
   logic [31:0] s_wdata = 32'h0;
   logic [3:0] s_wstrb = 4'hf;
   logic s_wvalid = 1'b0;
   logic s_wready;
   logic [1:0] s_bresp;
   logic s_bvalid;
   logic s_bready = 1'b0;
   logic [3:0] s_araddr = 4'h0;
   logic s_arvalid = 1'b0;
   logic s_arready;
   logic [31:0] s_rdata;
   logic [1:0] s_rresp;
   logic s_rvalid;
   logic s_rready = 1'b0;
   logic alloc_req;
   logic [3:0] alloc_pages;
   logic [4:0] enq_packet;
   logic [3:0] cur_endpoint;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_alloc = 0;

   pbma_if pbma_if_inst();
   pbma_dev pbma_dev_inst(.sys_clk(sys_clk), .srst(srst), .ce(ce), .bus(pbma_if_inst),
      .rx_top_packet(rx_top_packet), .alloc_req(alloc_req), .alloc_pages(alloc_pages),
      .enq_packet(enq_packet), .cur_endpoint(cur_endpoint));
   pbma_host pbma_host_inst(.sys_clk(sys_clk), .srst(srst), .ce(ce), .bus(pbma_if_inst),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready));
   pbma_properties pbma_properties_inst(.sys_clk(sys_clk), .srst(srst),
      .req(pbma_if_inst.req), .wr(pbma_if_inst.wr), .addr(pbma_if_inst.addr),
      .wdata(pbma_if_inst.wdata), .rdata(pbma_if_inst.rdata), .ack(pbma_if_inst.ack),
      .tx_pop(pbma_if_inst.tx_pop), .tx_pop_ep(pbma_if_inst.tx_pop_ep));

   always #2 sys_clk = ~sys_clk;

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (alloc_req === 1'b1) n_alloc <= n_alloc + 1;
      if (cyc == 40000) begin
         err_count++;
         end_sim();
      end
   end

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_awaddr <= a;
      s_awvalid <= 1'b1;
      s_wdata <= d;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      end while (s_bvalid !== 1'b1);
      chk({6'h0, s_bresp}, 8'h00);
      s_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      end while (s_rvalid !== 1'b1);
      d = s_rdata;
      chk({6'h0, s_rresp}, 8'h00);
      s_rready <= 1'b0;
   endtask : axi_rd

   // one access on the link, started through the host and polled to completion
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] q);
      logic [31:0] r;
      axi_wr(AXI_ADDR, {16'h0, a});
      axi_wr(AXI_WDATA, {24'h0, d});
      axi_wr(AXI_CTRL, {30'h0, w, 1'b1});
      r = 32'h1;
      while (r[0] !== 1'b0) axi_rd(AXI_CTRL, r);
      axi_rd(AXI_RDATA, r);
      q = r[7:0];
   endtask : acc

   // transmit pop on one endpoint, issued through the host's control register
   task automatic pop_ep(input logic [3:0] ep);
      axi_wr(AXI_ADDR, {28'h0, ep});
      axi_wr(AXI_CTRL, 32'h4);
   endtask : pop_ep

   task automatic wr8(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(1'b1, a, d, q);
   endtask : wr8

   task automatic rd8(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] q;
      acc(1'b0, a, 8'h0, q);
      chk(q, e);
   endtask : rd8

   task automatic t_window;
      logic [7:0] q;
      wr8(PKTSEL_ADDR, 8'h02);
      wr8(OFS_LOW_ADDR, 8'h10);
      wr8(OFS_HIGH_ADDR, 8'h41);
      wr8(WINDOW_ADDR, 8'ha5);
      wr8(WINDOW_ADDR, 8'h5a);
      wr8(OFS_LOW_ADDR, 8'h10);
      wr8(OFS_HIGH_ADDR, 8'h61);
      rd8(WINDOW_ADDR, 8'ha5);
      rd8(WINDOW_ADDR, 8'h5a);
      acc(1'b0, OFS_HIGH_ADDR, 8'h0, q);
      chk(q, 8'h61);
      rd8(OFS_LOW_ADDR, 8'h11);
      $display("window test done");
   endtask : t_window

   task automatic t_source;
      wr8(OFS_LOW_ADDR, 8'hfd);
      wr8(OFS_HIGH_ADDR, 8'h04);
      wr8(WINDOW_ADDR, 8'h77);
      rx_top_packet <= 5'h01;
      wr8(OFS_LOW_ADDR, 8'hfd);
      wr8(OFS_HIGH_ADDR, 8'h84);
      wr8(WINDOW_ADDR, 8'h88);
      wr8(OFS_LOW_ADDR, 8'hfd);
      wr8(OFS_HIGH_ADDR, 8'h24);
      rd8(WINDOW_ADDR, 8'h77);
      rd8(WINDOW_ADDR, 8'h77);
      wr8(OFS_LOW_ADDR, 8'hfd);
      wr8(OFS_HIGH_ADDR, 8'ha4);
      rd8(WINDOW_ADDR, 8'h88);
      $display("source test done");
   endtask : t_source

   task automatic t_cmd;
      int n0;
      n0 = n_alloc;
      wr8(CMD_ADDR, {CMD_ALLOC, 1'b1, 4'h9});
      chk({4'h0, alloc_pages}, 8'h09);
      chk(8'(n_alloc - n0), 8'h01);
      wr8(CMD_ADDR, {CMD_ALLOC, 1'b0, 4'ha});
      chk(8'(n_alloc - n0), 8'h01);
      rd8(CMD_ADDR, 8'h00);
      chk(8'(n_alloc - n0), 8'h01);
      $display("command test done");
   endtask : t_cmd

   task automatic t_queue;
      wr8(PKTSEL_ADDR, 8'h13);
      wr8(TXSEL_ADDR, 8'hf3);
      rd8(TXSEL_ADDR, 8'h03);
      chk({4'h0, cur_endpoint}, 8'h03);
      chk({3'h0, enq_packet}, 8'h13);
      wr8(CMD_ADDR, {CMD_ENQUEUE, 5'h0});
      rd8(QCNT_BASE + 16'h3, 8'h01);
      wr8(CMD_ADDR, {CMD_NOOP, 5'h0});
      rd8(QCNT_BASE + 16'h3, 8'h01);
      repeat (5) wr8(CMD_ADDR, {CMD_ENQUEUE, 5'h0});
      rd8(QCNT_BASE + 16'h3, {5'h0, QMAX});
      rd8(QCNT_BASE, 8'h00);
      wr8(TXSEL_ADDR, 8'h0f);
      wr8(CMD_ADDR, {CMD_ENQUEUE, 5'h0});
      rd8(QCNT_LAST, 8'h01);
      wr8(CMD_ADDR, {CMD_EP_RESET, 5'h0});
      rd8(QCNT_LAST, 8'h00);
      rd8(QCNT_BASE + 16'h3, {5'h0, QMAX});
      pop_ep(4'h3);
      rd8(QCNT_BASE + 16'h3, 8'h04);
      wr8(TXSEL_ADDR, 8'h03);
      wr8(CMD_ADDR, {CMD_EP_RESET, 5'h0});
      rd8(QCNT_BASE + 16'h3, 8'h00);
      pop_ep(4'h3);
      rd8(QCNT_BASE + 16'h3, 8'h00);
      $display("queue test done");
   endtask : t_queue

   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      t_window();
      t_source();
      t_cmd();
      t_queue();
      end_sim();
   end
endmodule : tb_packet_buffer_mcu_access
